// >>> shared/ebm_pkg.sv
// Constants, register map and carriers of the embedded block memory.
// Assumes one system clock; used only through ebm_pkg:: names.
package ebm_pkg;
	// ========================================
	// Array geometry
	localparam int MEM_BITS = 18432;
	localparam int MAX_W    = 36;
	localparam int ADDR_W   = 14;
	localparam int LANE_W   = 9;
	localparam int LANES    = 4;
	localparam int IDX_W    = 15;
	localparam int CP_WORDS = 512;
	localparam int CP_CNT_W = 9;
	localparam logic [ADDR_W-1:0] ADDR_FULL = 14'h3FFF;
	// ========================================
	// Port width codes, each halves the depth
	localparam logic [2:0] W_X1  = 3'h0;
	localparam logic [2:0] W_X2  = 3'h1;
	localparam logic [2:0] W_X4  = 3'h2;
	localparam logic [2:0] W_X9  = 3'h3;
	localparam logic [2:0] W_X18 = 3'h4;
	localparam logic [2:0] W_X36 = 3'h5;
	// ========================================
	// Memory modes
	localparam logic [1:0] M_SP  = 2'h0;
	localparam logic [1:0] M_TDP = 2'h1;
	localparam logic [1:0] M_PDP = 2'h2;
	// ========================================
	// Register map and fields
	localparam logic [7:0] REG_CFG  = 8'h00;
	localparam logic [7:0] REG_CMD  = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam int CMD_LOAD = 0;
	localparam int CMD_SAVE = 1;
	localparam int ST_BUSY  = 0;
	localparam int ST_ERR   = 1;
	localparam int HT_ACT   = 1;
	localparam int CFG_W    = 15;
	typedef struct packed {
		logic       par;
		logic       b_async;
		logic       a_async;
		logic       b_oreg;
		logic       a_oreg;
		logic       b_wt;
		logic       a_wt;
		logic [2:0] b_w;
		logic [2:0] a_w;
		logic [1:0] mode;
	} ebm_cfg_s;
	localparam ebm_cfg_s CFG_RST = 15'h0000;
	typedef struct packed {
		logic              ce;
		logic              we;
		logic [ADDR_W-1:0] addr;
		logic [MAX_W-1:0]  wdata;
		logic [LANES-1:0]  be;
	} ebm_req_s;
endpackage

// >>> core/ebm_core.sv
// Embedded block memory: 18 Kbit array, two fabric ports, AHB-Lite setup.
// Assumes fabric ports synchronous to clock; ce acts as the port clock.
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// R01: Array of 18 Kbit with registers at inputs and outputs.
// R02: Single port, true dual port or pseudo dual port modes.
// R03: Shapes 16384x1 to 512x36; true dual port lacks x36.
// R04: Optional parity bit per byte lane, generated and checked.
// R05: Byte enables qualify writes in x18 and x36 widths.
// R06: Each port has its own width and matching depth.
// R07: Bits map contiguously word by word, same on every port.
// R08: Write data and address registered on the port clock.
// R09: Read output register enabled or bypassed by setup.
// R10: Normal mode: output changes on reads only, never on writes.
// R11: Write-through: written data copied to same port output.
// R12: Output latches reset per port, async or sync chosen.
// R13: Active-low global reset clears both ports' output latches.
// R14: Global reset always acts asynchronously.
// R15: User holds clock enables low around async reset edges.
// R16: With enables high, reset only after clocks steady one period.
// R17: Preloaded block: global reset disabled or released before I/O.
// R18: Sync-only reset without global reset needs no sequencing.
// R19: Shadow contents loaded into array at power-up and reload.
// R20: Array contents can be saved back into the shadow.
// R21: Read data one clock after registering, one more with register.
module ebm_core #(
	parameter int WORDS = ebm_pkg::CP_WORDS
) (
	input  wire logic                   clock,
	input  wire logic                   rstn,
	input  wire logic                   global_reset_n,
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic [31:0]                 hrdata,
	input  wire ebm_pkg::ebm_req_s      req_a,
	input  wire ebm_pkg::ebm_req_s      req_b,
	input  wire logic                   port_a_output_reset,
	input  wire logic                   port_b_output_reset,
	output logic [ebm_pkg::MAX_W-1:0]   rdata_a,
	output logic [ebm_pkg::MAX_W-1:0]   rdata_b,
	output logic                        perr_a,
	output logic                        perr_b
);
	// ========================================
	// Elaboration check
	if (WORDS * ebm_pkg::MAX_W != ebm_pkg::MEM_BITS) begin : g_chk
		$error("WORDS must tile the array exactly");
	end

	// ========================================
	// Decoding helpers
	function automatic logic [5:0] wbits(input logic [2:0] w);
		case (w)
			ebm_pkg::W_X1:  wbits = 6'h01;
			ebm_pkg::W_X2:  wbits = 6'h02;
			ebm_pkg::W_X4:  wbits = 6'h04;
			ebm_pkg::W_X9:  wbits = 6'h09;
			ebm_pkg::W_X18: wbits = 6'h12;
			default:        wbits = 6'h24;
		endcase
	endfunction

	function automatic logic [ebm_pkg::IDX_W-1:0] bit_base(
		input logic [ebm_pkg::ADDR_W-1:0] a,
		input logic [2:0]                 w
	);
		logic [19:0] prod;
		prod = 20'(a & (ebm_pkg::ADDR_FULL >> w)) * 20'(wbits(w));
		bit_base = prod[ebm_pkg::IDX_W-1:0];
	endfunction

	function automatic logic is_wide(input logic [2:0] w);
		is_wide = (w == ebm_pkg::W_X18) || (w == ebm_pkg::W_X36);
	endfunction

	// ========================================
	// Declarations
	typedef enum logic [1:0] {CP_IDLE, CP_LOAD, CP_SAVE} ebm_cp_e;
	ebm_pkg::ebm_cfg_s cfg_ff;
	ebm_cp_e st_ff;
	ebm_cp_e nxt_st;
	logic [ebm_pkg::CP_CNT_W-1:0] cnt_ff;
	logic [7:0] ap_addr_ff;
	logic ap_wr_ff;
	logic [31:0] hrdata_ff;
	logic [ebm_pkg::MEM_BITS+ebm_pkg::MAX_W-1:0] mem_ff;
	logic [ebm_pkg::MEM_BITS-1:0] shadow_ff;
	ebm_pkg::ebm_req_s req [2];
	logic [1:0] prst;
	logic [1:0] can_rd;
	logic [1:0] can_wr;
	logic [1:0] rd_go;
	logic [1:0] wr_go;
	logic [2:0] pw [2];
	logic [ebm_pkg::IDX_W-1:0] base [2];
	logic [ebm_pkg::MAX_W-1:0] wdat [2];
	logic [ebm_pkg::MAX_W-1:0] wbm [2];
	logic [ebm_pkg::MAX_W-1:0] rdat [2];
	logic [ebm_pkg::MAX_W-1:0] rout [2];
	logic [1:0] perr;
	wire ap_take;
	wire busy;
	wire cfg_err;
	wire ports_on;
	wire cmd_load;
	wire cmd_save;
	wire last_word;
	wire [31:0] stat_word;
	wire [31:0] rd_mux;
	wire [ebm_pkg::IDX_W-1:0] cp_base;

	assign req[0] = req_a;
	assign req[1] = req_b;
	assign prst   = {port_b_output_reset, port_a_output_reset};

	// ========================================
	// AHB-Lite slave, zero wait states
	assign ap_take   = hsel && htrans[ebm_pkg::HT_ACT] && hready;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_ff;
	assign stat_word = (32'(cfg_err) << ebm_pkg::ST_ERR)
		| (32'(busy) << ebm_pkg::ST_BUSY);
	assign rd_mux = (haddr[7:0] == ebm_pkg::REG_CFG) ? 32'(cfg_ff)
		: (haddr[7:0] == ebm_pkg::REG_STAT) ? stat_word : 32'h0000_0000;
	assign cmd_load = ap_wr_ff && (ap_addr_ff == ebm_pkg::REG_CMD)
		&& hwdata[ebm_pkg::CMD_LOAD];
	assign cmd_save = ap_wr_ff && (ap_addr_ff == ebm_pkg::REG_CMD)
		&& hwdata[ebm_pkg::CMD_SAVE];

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ap_wr_ff   <= 1'b0;
			ap_addr_ff <= 8'h00;
			hrdata_ff  <= 32'h0000_0000;
		end else begin
			ap_wr_ff   <= ap_take && hwrite;
			ap_addr_ff <= haddr[7:0];
			if (ap_take && !hwrite) begin
				hrdata_ff <= rd_mux;
			end
		end
	end

	// Setup changes take effect at once; quiesce ports first
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cfg_ff <= ebm_pkg::CFG_RST;
		end else if (ap_wr_ff && ap_addr_ff == ebm_pkg::REG_CFG) begin
			cfg_ff <= ebm_pkg::ebm_cfg_s'(hwdata[ebm_pkg::CFG_W-1:0]);
		end
	end

	// ========================================
	// Mode and shape decode
	assign cfg_err = (cfg_ff.mode > ebm_pkg::M_PDP)
		|| (cfg_ff.a_w > ebm_pkg::W_X36) || (cfg_ff.b_w > ebm_pkg::W_X36)
		|| ((cfg_ff.mode == ebm_pkg::M_TDP)
		&& ((cfg_ff.a_w == ebm_pkg::W_X36)
		|| (cfg_ff.b_w == ebm_pkg::W_X36)));                    // [R03]
	assign ports_on  = !busy && !cfg_err;
	assign can_rd[0] = ports_on && (cfg_ff.mode != ebm_pkg::M_PDP); // [R02]
	assign can_wr[0] = ports_on;
	assign can_rd[1] = ports_on && (cfg_ff.mode != ebm_pkg::M_SP);  // [R02]
	assign can_wr[1] = ports_on && (cfg_ff.mode == ebm_pkg::M_TDP); // [R02]

	// ========================================
	// Shadow copy engine, one word per clock
	assign busy      = (st_ff != CP_IDLE);
	assign last_word = (cnt_ff == ebm_pkg::CP_CNT_W'(WORDS - 1));
	assign cp_base   = ebm_pkg::IDX_W'(cnt_ff)
		* ebm_pkg::IDX_W'(ebm_pkg::MAX_W);

	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			CP_IDLE: begin
				if (cmd_load) begin
					nxt_st = CP_LOAD;                           // [R19]
				end else if (cmd_save) begin
					nxt_st = CP_SAVE;                           // [R20]
				end
			end
			CP_LOAD, CP_SAVE: begin
				if (last_word) begin
					nxt_st = CP_IDLE;
				end
			end
			default: nxt_st = CP_IDLE;
		endcase
	end

	// Power-up starts with a load from the shadow
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_ff  <= CP_LOAD;                                  // [R19]
			cnt_ff <= '0;
		end else begin
			st_ff  <= nxt_st;
			cnt_ff <= (st_ff == CP_IDLE || last_word) ? '0 : cnt_ff + 1'b1;
		end
	end

	// ========================================
	// Storage; port A wins a same-bit collision
	always_ff @(posedge clock) begin
		if (st_ff == CP_LOAD) begin
			mem_ff[cp_base +: ebm_pkg::MAX_W] <=
				shadow_ff[cp_base +: ebm_pkg::MAX_W];           // [R19]
		end
		for (int p = 1; p >= 0; p--) begin
			for (int i = 0; i < ebm_pkg::MAX_W; i++) begin
				if (wr_go[p] && wbm[p][i]) begin
					mem_ff[base[p] + ebm_pkg::IDX_W'(i)] <= wdat[p][i]; // [R01][R07]
				end
			end
		end
	end

	// Nonvolatile copy: no reset
	always_ff @(posedge clock) begin
		if (st_ff == CP_SAVE) begin
			shadow_ff[cp_base +: ebm_pkg::MAX_W] <=
				mem_ff[cp_base +: ebm_pkg::MAX_W];              // [R20]
		end
	end

	// ========================================
	// Port pipelines
	for (genvar p = 0; p < 2; p++) begin : g_port
		ebm_pkg::ebm_req_s in_ff;
		logic act_ff;
		logic upd_ff;
		logic lat_rst_n;
		logic wt;
		logic oreg;
		logic [ebm_pkg::MAX_W-1:0] wmask;
		logic [ebm_pkg::MAX_W-1:0] lat_ff;
		logic [ebm_pkg::MAX_W-1:0] oreg_ff;
		logic [ebm_pkg::MAX_W-1:0] wd;
		logic [ebm_pkg::MAX_W-1:0] bm;
		logic [ebm_pkg::LANES-1:0] bad;

		assign pw[p]   = (p == 0) ? cfg_ff.a_w : cfg_ff.b_w;      // [R06]
		assign wt      = (p == 0) ? cfg_ff.a_wt : cfg_ff.b_wt;
		assign oreg    = (p == 0) ? cfg_ff.a_oreg : cfg_ff.b_oreg;
		assign wmask   = {ebm_pkg::MAX_W{1'b1}}
			>> (ebm_pkg::MAX_W - int'(wbits(pw[p])));
		assign base[p] = bit_base(in_ff.addr, pw[p]);             // [R07]
		assign rdat[p] = mem_ff[base[p] +: ebm_pkg::MAX_W] & wmask;
		assign rd_go[p] = act_ff && !in_ff.we && can_rd[p];
		assign wr_go[p] = act_ff && in_ff.we && can_wr[p];
		assign wdat[p] = wd;
		assign wbm[p]  = bm;

		always_comb begin
			wd = in_ff.wdata & wmask;
			bm = wmask;
			bad = '0;
			for (int l = 0; l < ebm_pkg::LANES; l++) begin
				if (cfg_ff.par && pw[p] >= ebm_pkg::W_X9) begin
					wd[l*ebm_pkg::LANE_W+ebm_pkg::LANE_W-1] =
						wmask[l*ebm_pkg::LANE_W]
						&& (^in_ff.wdata[l*ebm_pkg::LANE_W +: 8]); // [R04]
					bad[l] = wmask[l*ebm_pkg::LANE_W]
						&& (^rout[p][l*ebm_pkg::LANE_W +: ebm_pkg::LANE_W]); // [R04]
				end
				if (is_wide(pw[p]) && !in_ff.be[l]) begin
					bm[l*ebm_pkg::LANE_W +: ebm_pkg::LANE_W] = '0; // [R05]
				end
			end
		end

		assign rout[p] = oreg ? oreg_ff : lat_ff;                 // [R09]

		// Input registers on the port clock enable
		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				in_ff  <= '0;
				act_ff <= 1'b0;
				upd_ff <= 1'b0;
			end else begin
				act_ff <= req[p].ce;                            // [R08]
				upd_ff <= rd_go[p] || (wr_go[p] && wt);
				if (req[p].ce) begin
					in_ff <= req[p];                            // [R08]
				end
			end
		end

		// Global reset always async; local reset async if chosen
		assign lat_rst_n = rstn && global_reset_n
			&& !(((p == 0) ? cfg_ff.a_async : cfg_ff.b_async)
			&& prst[p]);                                     // [R12][R13][R14]

		always_ff @(posedge clock or negedge lat_rst_n) begin
			if (!lat_rst_n) begin
				lat_ff  <= '0;
				oreg_ff <= '0;
			end else if (prst[p]) begin
				lat_ff  <= '0;                                  // [R12]
				oreg_ff <= '0;
			end else begin
				if (rd_go[p]) begin
					lat_ff <= rdat[p];                          // [R10][R21]
				end else if (wr_go[p] && wt) begin
					lat_ff <= wd;                               // [R11]
				end
				if (upd_ff) begin
					oreg_ff <= lat_ff;                          // [R09][R21]
				end
			end
		end

		assign perr[p] = |bad;

		// ========================================
		// Checks
		property p_in_reg;
			@(posedge clock) disable iff (!rstn)
			req[p].ce |=> act_ff && (in_ff == $past(req[p]));
		endproperty
		a_in_reg: assert property (p_in_reg) // [R08]
			else $error("input register missed a request");

		property p_rd_lat;
			@(posedge clock) disable iff (!lat_rst_n)
			rd_go[p] && !prst[p] |=> lat_ff == $past(rdat[p]);
		endproperty
		a_rd_lat: assert property (p_rd_lat) // [R21]
			else $error("read data not in latch one clock later");

		property p_normal;
			@(posedge clock) disable iff (!lat_rst_n)
			wr_go[p] && !wt && !prst[p] |=> $stable(lat_ff);
		endproperty
		a_normal: assert property (p_normal) // [R10]
			else $error("normal write disturbed output");

		property p_wthru;
			@(posedge clock) disable iff (!lat_rst_n)
			wr_go[p] && wt && !prst[p] |=> lat_ff == $past(wd);
		endproperty
		a_wthru: assert property (p_wthru) // [R11]
			else $error("write-through data missing");

		property p_oreg;
			@(posedge clock) disable iff (!lat_rst_n)
			(rd_go[p] && !prst[p]) ##1 !prst[p] |=> oreg_ff == $past(rdat[p], 2);
		endproperty
		a_oreg: assert property (p_oreg) // [R09]
			else $error("output register not one clock behind");

		property p_lrst;
			@(posedge clock) disable iff (!rstn || !global_reset_n)
			prst[p] |=> lat_ff == '0 && oreg_ff == '0;
		endproperty
		a_lrst: assert property (p_lrst) // [R12]
			else $error("local reset left output latch set");

		property p_grst;
			@(posedge clock) disable iff (!rstn)
			!global_reset_n |-> lat_ff == '0 && rout[p] == '0;
		endproperty
		a_grst: assert property (p_grst) // [R13]
			else $error("global reset did not clear output");

		property p_mem;
			@(posedge clock)
			wr_go[p] && wbm[p][0] && (p == 0 || !wr_go[0])
			|=> mem_ff[$past(base[p])] == $past(wdat[p][0]);
		endproperty
		a_mem: assert property (p_mem) // [R07]
			else $error("array bit not written at linear index");
	end

	assign rdata_a = rout[0];
	assign rdata_b = rout[1];
	assign perr_a  = perr[0];
	assign perr_b  = perr[1];

	// ========================================
	// Copy length watch; a counter, the span is too long to unroll
	logic [ebm_pkg::CP_CNT_W:0] busy_run_ff;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			busy_run_ff <= '0;
		end else begin
			busy_run_ff <= busy ? busy_run_ff + 1'b1 : '0;
		end
	end

	property p_load_len;
		@(posedge clock) disable iff (!rstn)
		$fell(busy) |-> busy_run_ff == (ebm_pkg::CP_CNT_W + 1)'(WORDS);
	endproperty
	a_load_len: assert property (p_load_len) // [R19]
		else $error("shadow copy did not last one word per clock");

	property p_load_max;
		@(posedge clock) disable iff (!rstn)
		busy |-> busy_run_ff < (ebm_pkg::CP_CNT_W + 1)'(WORDS);
	endproperty
	a_load_max: assert property (p_load_max) // [R20]
		else $error("shadow copy overran the array");
endmodule

// >>> verif/ebm_fabric.sv
// Fabric user logic model driving both memory ports and their resets.
// Assumes the bench calls its tasks; shares the memory's clock.
`timescale 1ns/1ps
module ebm_fabric (
	input  wire logic         clock,
	output ebm_pkg::ebm_req_s req_a,
	output ebm_pkg::ebm_req_s req_b,
	output logic              port_a_output_reset,
	output logic              port_b_output_reset,
	output logic              global_reset_n
);
	// ========================================
	// Idle state
	initial begin
		req_a = '0;
		req_b = '0;
		port_a_output_reset = 1'b0;
		port_b_output_reset = 1'b0;
		global_reset_n = 1'b1; // Held off while preloading
	end
	// ========================================
	// Requests: one enabled edge, then released lines go inverted
	task automatic op(input logic p, input logic we, input logic [13:0] a,
		input logic [35:0] d, input logic [3:0] be);
		ebm_pkg::ebm_req_s r;
		r = '{1'b1, we, a, d, be};
		@(posedge clock);
		if (p)
			req_b <= r;
		else
			req_a <= r;
		@(posedge clock);
		r = '{1'b0, ~we, ~a, ~d, ~be};
		if (p)
			req_b <= r;
		else
			req_a <= r;
	endtask
	// ========================================
	// Resets
	task automatic lrst(input logic p, input logic on);
		@(posedge clock); // Sync local reset needs no sequencing
		if (p)
			port_b_output_reset <= on;
		else
			port_a_output_reset <= on;
	endtask
	task automatic gres(input logic on);
		@(posedge clock); // Enables low a cycle around both edges
		global_reset_n <= ~on;
	endtask
endmodule

// >>> verif/embedded_block_ram_tb.sv
// Self-checking bench for the block memory: AHB setup, fabric traffic.
// Assumes ebm_core and the ebm_fabric model; one 10 MHz clock.
`timescale 1ns/1ps
module embedded_block_ram_tb;
	logic                         clock;
	logic                         rstn;
	logic                         hsel;
	logic [31:0]                  haddr;
	logic [1:0]                   htrans;
	logic                         hwrite;
	logic [2:0]                   hsize;
	logic [31:0]                  hwdata;
	logic                         hreadyout;
	logic                         hresp;
	logic [31:0]                  hrdata;
	ebm_pkg::ebm_req_s            req_a;
	ebm_pkg::ebm_req_s            req_b;
	logic                         port_a_output_reset;
	logic                         port_b_output_reset;
	logic                         global_reset_n;
	logic [35:0]                  rdata_a;
	logic [35:0]                  rdata_b;
	logic                         perr_a;
	logic                         perr_b;
	logic [ebm_pkg::MEM_BITS-1:0] mdl;
	logic [ebm_pkg::MEM_BITS-1:0] shd;
	logic                         par;
	logic [31:0]                  rv;
	logic [31:0]                  cw;
	logic [13:0]                  ad [3];
	logic [35:0]                  dv;
	int                           n_mismatch;
	int                           n_tests;
	// ========================================
	// Design and fabric model
	ebm_core #(.WORDS(ebm_pkg::CP_WORDS)) u_dut (
		.clock(clock), .rstn(rstn), .global_reset_n(global_reset_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.req_a(req_a), .req_b(req_b),
		.port_a_output_reset(port_a_output_reset),
		.port_b_output_reset(port_b_output_reset),
		.rdata_a(rdata_a), .rdata_b(rdata_b),
		.perr_a(perr_a), .perr_b(perr_b));
	ebm_fabric u_fab (
		.clock(clock), .req_a(req_a), .req_b(req_b),
		.port_a_output_reset(port_a_output_reset),
		.port_b_output_reset(port_b_output_reset),
		.global_reset_n(global_reset_n));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// ========================================
	// Reference array model
	function automatic int wid(input logic [2:0] c);
		return (c < 3'h3) ? (1 << c) : (9 << (c - 3'h3));
	endfunction
	function automatic int bas(input logic [13:0] a, input logic [2:0] c);
		return int'(a & (ebm_pkg::ADDR_FULL >> c)) * wid(c);
	endfunction
	function automatic logic [35:0] mrd(input logic [13:0] a,
		input logic [2:0] c);
		logic [35:0] r;
		r = 36'h0;
		for (int b = 0; b < wid(c); b++)
			r[b] = mdl[bas(a, c) + b];
		return r;
	endfunction
	task automatic mwr(input logic [13:0] a, input logic [2:0] c,
		input logic [35:0] d, input logic [3:0] be);
		for (int b = 0; b < wid(c); b++) begin
			if (c < 3'h4 || be[b / 9])
				mdl[bas(a, c) + b] = (par && c > 3'h2 && b % 9 == 8) ?
					^d[b - 8 +: 8] : d[b];
		end
	endtask
	// ========================================
	// Checking and closing
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic fail;
		n_mismatch++;
		$display("ERROR %0t wait ran out", $time);
		complete_run();
	endtask
	// ========================================
	// Bus and port tasks
	task automatic hwait;
		int i;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (hreadyout !== 1'b1 && i < 16);
		if (hreadyout !== 1'b1)
			fail();
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		hwait();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		hwait();
		rv = hrdata;
	endtask
	task automatic setc(input logic [1:0] m, input logic [2:0] aw,
		input logic [2:0] bw, input logic [6:0] f);
		cw = {17'h0, f, bw, aw, m};
		ahb(1'b1, ebm_pkg::REG_CFG, cw);
		par = f[6];
	endtask
	task automatic idle;
		for (int i = 0; i < 400; i++) begin
			ahb(1'b0, ebm_pkg::REG_STAT, 32'h0);
			if (rv[ebm_pkg::ST_BUSY] === 1'b0)
				return;
		end
		fail();
	endtask
	task automatic cerr(input logic [1:0] m, input logic [2:0] w,
		input logic e);
		setc(m, w, w, 7'h0);
		ahb(1'b0, ebm_pkg::REG_STAT, 32'h0);
		chk(36'(rv[ebm_pkg::ST_ERR]), 36'(e));
	endtask
	task automatic wr(input logic p, input logic [13:0] a,
		input logic [2:0] c, input logic [35:0] d, input logic [3:0] be);
		u_fab.op(p, 1'b1, a, d, be);
		mwr(a, c, d, be);
	endtask
	task automatic rd(input logic p, input logic [13:0] a,
		input logic [2:0] c, input logic o);
		logic [35:0] old;
		old = p ? rdata_b : rdata_a;
		u_fab.op(p, 1'b0, a, 36'h0, 4'h0);
		#1 chk(p ? rdata_b : rdata_a, old);
		if (o) begin
			@(posedge clock);
			#1 chk(p ? rdata_b : rdata_a, old);
		end
		@(posedge clock);
		#1 chk(p ? rdata_b : rdata_a, mrd(a, c));
	endtask
	// ========================================
	// Main sequence
	initial begin
		rstn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		par = 1'b0;
		n_mismatch = 0;
		n_tests = 0;
		mdl = 'x;
		void'($urandom(33));
		repeat (6) @(posedge clock);
		chk(rdata_a | rdata_b, 36'h0);
		rstn <= 1'b1;
		ahb(1'b0, ebm_pkg::REG_STAT, 32'h0);
		chk(36'(rv[ebm_pkg::ST_BUSY]), 36'h1);
		idle();
		ahb(1'b0, 8'h0C, 32'h0);
		chk(36'(rv), 36'h0);
		ahb(1'b0, ebm_pkg::REG_CMD, 32'h0);
		chk(36'(rv), 36'h0);
		setc(ebm_pkg::M_SP, 3'h1, 3'h1, 7'($urandom));
		ahb(1'b0, ebm_pkg::REG_CFG, 32'h0);
		chk(36'(rv), 36'(cw));
		chk(36'(hresp), 36'h0);
		$display("test registers done");
		for (int c = 0; c < 6; c++) begin
			setc(ebm_pkg::M_SP, 3'(c), 3'h0, 7'h0);
			for (int k = 0; k < 3; k++) begin
				ad[k] = 14'($urandom);
				wr(1'b0, ad[k], 3'(c), {4'($urandom), $urandom}, 4'hF);
			end
			for (int k = 0; k < 3; k++)
				rd(1'b0, ad[k], 3'(c), 1'b0);
		end
		$display("test widths done");
		setc(ebm_pkg::M_PDP, ebm_pkg::W_X36, ebm_pkg::W_X9, 7'h08);
		wr(1'b0, 14'h5, ebm_pkg::W_X36, {4'($urandom), $urandom}, 4'hF);
		for (int l = 0; l < 4; l++)
			rd(1'b1, 14'(20 + l), ebm_pkg::W_X9, 1'b1);
		dv = rdata_a;
		u_fab.op(1'b0, 1'b0, 14'h5, 36'h0, 4'h0);
		repeat (2) @(posedge clock);
		#1 chk(rdata_a, dv);
		setc(ebm_pkg::M_PDP, ebm_pkg::W_X36, ebm_pkg::W_X1, 7'h0);
		rd(1'b1, 14'h0BE, ebm_pkg::W_X1, 1'b0);
		$display("test mixed widths done");
		setc(ebm_pkg::M_SP, ebm_pkg::W_X18, 3'h0, 7'h0);
		wr(1'b0, 14'h33, ebm_pkg::W_X18, {4'($urandom), $urandom}, 4'hF);
		rd(1'b0, 14'h33, ebm_pkg::W_X18, 1'b0);
		dv = rdata_a;
		wr(1'b0, 14'h33, ebm_pkg::W_X18, ~dv, 4'h3);
		repeat (2) @(posedge clock);
		#1 chk(rdata_a, dv);
		setc(ebm_pkg::M_SP, ebm_pkg::W_X18, 3'h0, 7'h01);
		wr(1'b0, 14'h33, ebm_pkg::W_X18, 36'($urandom), 4'h3);
		@(posedge clock);
		#1 chk(rdata_a, mrd(14'h33, ebm_pkg::W_X18));
		for (int c = 4; c < 6; c++) begin
			setc(ebm_pkg::M_SP, 3'(c), 3'h0, 7'h0);
			wr(1'b0, 14'h33, 3'(c), {4'($urandom), $urandom}, 4'hF);
			wr(1'b0, 14'h33, 3'(c), {4'($urandom), $urandom}, 4'($urandom));
			rd(1'b0, 14'h33, 3'(c), 1'b0);
		end
		$display("test write modes done");
		setc(ebm_pkg::M_SP, ebm_pkg::W_X9, 3'h0, 7'h0);
		wr(1'b0, 14'h2, ebm_pkg::W_X9, 36'h001, 4'h0);
		setc(ebm_pkg::M_SP, ebm_pkg::W_X9, 3'h0, 7'h40);
		rd(1'b0, 14'h2, ebm_pkg::W_X9, 1'b0);
		chk(36'(perr_a), 36'h1);
		wr(1'b0, 14'h3, ebm_pkg::W_X9, 36'h007, 4'h0);
		rd(1'b0, 14'h3, ebm_pkg::W_X9, 1'b0);
		chk(36'(perr_a), 36'h0);
		$display("test parity done");
		setc(ebm_pkg::M_TDP, ebm_pkg::W_X9, ebm_pkg::W_X9, 7'h60);
		rd(1'b0, 14'h2, ebm_pkg::W_X9, 1'b0);
		rd(1'b1, 14'h3, ebm_pkg::W_X9, 1'b0);
		chk(36'(perr_b), 36'h0);
		u_fab.lrst(1'b0, 1'b1);
		#1 chk(rdata_a, 36'h001);
		@(posedge clock);
		#1 chk(rdata_a, 36'h0);
		chk(rdata_b, 36'h107);
		u_fab.lrst(1'b0, 1'b0);
		u_fab.lrst(1'b1, 1'b1);
		#1 chk(rdata_b, 36'h0);
		u_fab.lrst(1'b1, 1'b0);
		rd(1'b0, 14'h3, ebm_pkg::W_X9, 1'b0);
		rd(1'b1, 14'h2, ebm_pkg::W_X9, 1'b0);
		chk(36'(perr_b), 36'h1);
		u_fab.gres(1'b1);
		#1 chk(rdata_a | rdata_b, 36'h0);
		u_fab.gres(1'b0);
		rd(1'b0, 14'h2, ebm_pkg::W_X9, 1'b0);
		$display("test resets done");
		cerr(ebm_pkg::M_TDP, ebm_pkg::W_X36, 1'b1);
		cerr(2'h3, ebm_pkg::W_X1, 1'b1);
		cerr(ebm_pkg::M_SP, 3'h6, 1'b1);
		cerr(ebm_pkg::M_TDP, ebm_pkg::W_X18, 1'b0);
		cerr(ebm_pkg::M_PDP, ebm_pkg::W_X36, 1'b0);
		$display("test config errors done");
		setc(ebm_pkg::M_SP, ebm_pkg::W_X36, 3'h0, 7'h0);
		wr(1'b0, 14'h9, ebm_pkg::W_X36, {4'($urandom), $urandom}, 4'hF);
		ahb(1'b1, ebm_pkg::REG_CMD, 32'h2);
		shd = mdl;
		idle();
		wr(1'b0, 14'h9, ebm_pkg::W_X36, {4'($urandom), $urandom}, 4'hF);
		ahb(1'b1, ebm_pkg::REG_CMD, 32'h1);
		mdl = shd;
		idle();
		rd(1'b0, 14'h9, ebm_pkg::W_X36, 1'b0);
		$display("test shadow done");
		complete_run();
	end
endmodule
